// ==== rtl/ppifc_pkg.sv ====
/*
 shared constants and types for the four-generator pwm block.
 assumes byte addresses on an ahb-lite bus, one 32-bit word per register.
*/
package ppifc_pkg;
    localparam int NUM_GEN = 4;
    localparam int NUM_OUT = 8;
    // block index in haddr[8:6]: 0 module, 1..4 generators 0..3
    localparam logic [2:0] MOD_BLK = 3'h0;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_MIEN = 6'h04;
    localparam logic [5:0] OFF_MRIS = 6'h08;
    localparam logic [5:0] OFF_MMIS = 6'h0C;
    localparam logic [5:0] OFF_SUPP = 6'h10;
    localparam logic [5:0] OFF_FLVL = 6'h14;
    localparam logic [5:0] OFF_SENSE = 6'h18;
    localparam logic [5:0] OFF_GCTL = 6'h00;
    localparam logic [5:0] OFF_PERIOD = 6'h04;
    localparam logic [5:0] OFF_CMPA = 6'h08;
    localparam logic [5:0] OFF_CMPB = 6'h0C;
    localparam logic [5:0] OFF_GIEN = 6'h10;
    localparam logic [5:0] OFF_GRIS = 6'h14;
    localparam logic [5:0] OFF_GMIS = 6'h18;
    localparam logic [5:0] OFF_COUNT = 6'h1C;
    // ctrl bits 3:0 run generators, bit 4 extended fault handling
    localparam int CTRL_EXT_BIT = 4;
    localparam int TRIG_LSB = 8;
    localparam int FSRC_LSB = 4;
    localparam logic [3:0] FAULT_SRC_RST = 4'h1;
    localparam logic [3:0] FAULT_SRC_LEGACY = 4'h1;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} ppifc_bus_e;

    typedef struct packed {
        logic [3:0] fault_src;
        logic updown;
    } ppifc_gcfg_s;

    typedef struct packed {
        logic cmpb_falling_count;
        logic cmpb_rising_count;
        logic cmpa_falling_count;
        logic cmpa_rising_count;
        logic counter_load;
        logic counter_zero;
    } ppifc_evt_s;
endpackage

// ==== rtl/ppifc_pwm.sv ====
/*
 four-generator pwm block: counters, buffered period and compare, event
 interrupts and triggers, module interrupt status, fault suppression.
 assumes one 50 MHz clock, synchronous active-high reset, an ahb-lite master
 doing single word transfers, and fault inputs synchronous to the clock.
*/
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Operation
// [RL1] per-generator enable bits unmask six interrupt and six trigger events
// [RL2] period is the tick count between successive counter-zero pulses
// [RL3] period writes stay pending; reads return the programmed value
// [RL4] a second write before the update replaces the pending value
// [RL5] module interrupt enable: one bit per generator and per fault input
// [RL6] raw and masked status exist for the module and each generator
// [RL7] suppressed outputs go inactive while their generator is faulted
// [RL8] unsuppressed outputs keep their waveform during a fault
// [RL9] without extended fault handling a suppressed output is driven low
// [RL10] with extended handling the fault-level bit picks high or low
// [RL11] fault-level bit matters only when suppression is selected
// [RL12] writing one to a generator status bit clears it; zero keeps it
// [RL13] pending period and compare updates apply when the counter hits zero
// [RL14] generator fault is OR of enabled, sense-adjusted inputs; default input 0
// [RL15] interrupt output is high while any module masked status bit is set
module ppifc_pwm #(
    parameter int PERIOD_W = 16
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [3:0] fault_in,
    output logic [7:0] pwm_out,
    output logic [3:0] trig_out,
    output logic irq_out
);
    ppifc_pkg::ppifc_bus_e bus_q, bus_d;
    logic [8:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d, rd_mux;
    logic [4:0] ctrl_q, ctrl_d;
    logic [7:0] mien_q, mien_d, mris_q, mris_d, supp_q, supp_d, flvl_q, flvl_d;
    logic [3:0] sense_q, sense_d;
    ppifc_pkg::ppifc_gcfg_s [3:0] gcfg_q, gcfg_d;
    logic [3:0][PERIOD_W-1:0] cnt_q, cnt_d, per_q, per_d, perp_q, perp_d, top;
    logic [3:0][PERIOD_W-1:0] cmpa_q, cmpa_d, cmpap_q, cmpap_d;
    logic [3:0][PERIOD_W-1:0] cmpb_q, cmpb_d, cmpbp_q, cmpbp_d;
    logic [3:0] dn_q, dn_d, upd_q, upd_d, trig_q, trig_d;
    logic [3:0][13:0] gien_q, gien_d;
    logic [3:0][5:0] gris_q, gris_d;
    ppifc_pkg::ppifc_evt_s [3:0] ev;
    logic [7:0] pwm_q, pwm_d;
    logic irq_q, irq_d;
    logic wr_now, ext;
    logic [2:0] blk;
    logic [5:0] off;
    logic [1:0] gi;
    logic [3:0] fault_adj, gfault, wgen;
    logic wmod;

    assign blk = addr_q[8:6];
    assign off = addr_q[5:0];
    assign gi = 2'(blk - 3'h1);
    assign wr_now = bus_q == ppifc_pkg::BUS_WR;
    assign wmod = wr_now && blk == ppifc_pkg::MOD_BLK;
    assign ext = ctrl_q[ppifc_pkg::CTRL_EXT_BIT];
    assign fault_adj = fault_in ^ sense_q;
    assign hrdata_out = rdata_q;
    // reads take one wait state so a write just before is already visible
    assign hreadyout_out = bus_q != ppifc_pkg::BUS_RD_WAIT;
    assign hresp_out = 1'b0;
    assign pwm_out = pwm_q;
    assign trig_out = trig_q;
    assign irq_out = irq_q;

    always_comb begin
        for (int g = 0; g < 4; g++) begin
            wgen[g] = wr_now && blk == 3'(g + 1);
            // legacy mode listens to fault input zero only
            gfault[g] = |((ext ? gcfg_q[g].fault_src : ppifc_pkg::FAULT_SRC_LEGACY)
                & fault_adj); // see [RL14]
        end
    end

    always_comb begin
        rd_mux = '0;
        if (blk == ppifc_pkg::MOD_BLK) begin
            case (off)
                ppifc_pkg::OFF_CTRL: rd_mux = 32'(ctrl_q);
                ppifc_pkg::OFF_MIEN: rd_mux = 32'(mien_q);
                ppifc_pkg::OFF_MRIS: rd_mux = 32'(mris_q); // see [RL6]
                ppifc_pkg::OFF_MMIS: rd_mux = 32'(mris_q & mien_q); // see [RL6]
                ppifc_pkg::OFF_SUPP: rd_mux = 32'(supp_q);
                ppifc_pkg::OFF_FLVL: rd_mux = 32'(flvl_q);
                ppifc_pkg::OFF_SENSE: rd_mux = 32'(sense_q);
                default: rd_mux = '0;
            endcase
        end else if (blk <= 3'h4) begin
            case (off)
                ppifc_pkg::OFF_GCTL: rd_mux = 32'(gcfg_q[gi]);
                ppifc_pkg::OFF_PERIOD: rd_mux = 32'(perp_q[gi]); // see [RL3]
                ppifc_pkg::OFF_CMPA: rd_mux = 32'(cmpap_q[gi]);
                ppifc_pkg::OFF_CMPB: rd_mux = 32'(cmpbp_q[gi]);
                ppifc_pkg::OFF_GIEN: rd_mux = 32'(gien_q[gi]);
                ppifc_pkg::OFF_GRIS: rd_mux = 32'(gris_q[gi]); // see [RL6]
                ppifc_pkg::OFF_GMIS: rd_mux = 32'(gris_q[gi] & gien_q[gi][5:0]);
                ppifc_pkg::OFF_COUNT: rd_mux = 32'(cnt_q[gi]);
                default: rd_mux = '0;
            endcase
        end
    end

    always_comb begin
        bus_d = bus_q;
        addr_d = addr_q;
        rdata_d = rdata_q;
        if (bus_q == ppifc_pkg::BUS_RD_WAIT) begin
            rdata_d = rd_mux;
            bus_d = ppifc_pkg::BUS_RD_DONE;
        end else if (hsel_in && htrans_in[1] && hready_in) begin
            addr_d = haddr_in[8:0];
            bus_d = hwrite_in ? ppifc_pkg::BUS_WR : ppifc_pkg::BUS_RD_WAIT;
        end else begin
            bus_d = ppifc_pkg::BUS_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bus_q <= ppifc_pkg::BUS_IDLE;
            addr_q <= '0;
            rdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        mien_d = mien_q;
        supp_d = supp_q;
        flvl_d = flvl_q;
        sense_d = sense_q;
        gcfg_d = gcfg_q;
        cnt_d = cnt_q;
        dn_d = dn_q;
        per_d = per_q;
        perp_d = perp_q;
        cmpa_d = cmpa_q;
        cmpap_d = cmpap_q;
        cmpb_d = cmpb_q;
        cmpbp_d = cmpbp_q;
        upd_d = upd_q;
        gien_d = gien_q;
        gris_d = gris_q;
        trig_d = '0;
        mris_d = mris_q;
        pwm_d = '0;
        if (wmod) begin
            case (off)
                ppifc_pkg::OFF_CTRL: ctrl_d = hwdata_in[4:0];
                ppifc_pkg::OFF_MIEN: mien_d = hwdata_in[7:0]; // see [RL5]
                ppifc_pkg::OFF_SUPP: supp_d = hwdata_in[7:0];
                ppifc_pkg::OFF_FLVL: flvl_d = hwdata_in[7:0];
                ppifc_pkg::OFF_SENSE: sense_d = hwdata_in[3:0];
                default: ;
            endcase
        end
        for (int g = 0; g < 4; g++) begin
            top[g] = gcfg_q[g].updown ? (per_q[g] >> 1) : PERIOD_W'(per_q[g] - 1'b1);
            ev[g] = '0;
            if (ctrl_q[g]) begin
                ev[g].counter_zero = cnt_q[g] == '0; // see [RL2]
                ev[g].counter_load = cnt_q[g] == top[g];
                ev[g].cmpa_rising_count = cnt_q[g] == cmpa_q[g] && !dn_q[g];
                ev[g].cmpa_falling_count = cnt_q[g] == cmpa_q[g] && dn_q[g];
                ev[g].cmpb_rising_count = cnt_q[g] == cmpb_q[g] && !dn_q[g];
                ev[g].cmpb_falling_count = cnt_q[g] == cmpb_q[g] && dn_q[g];
            end
            // a stopped counter sits at zero, so updates land at once
            if (!ctrl_q[g]) begin
                cnt_d[g] = '0;
                dn_d[g] = 1'b0;
            end else if (gcfg_q[g].updown) begin
                if (dn_q[g]) begin
                    if (cnt_q[g] == '0) begin
                        dn_d[g] = 1'b0;
                        cnt_d[g] = PERIOD_W'(top[g] != '0);
                    end else begin
                        cnt_d[g] = PERIOD_W'(cnt_q[g] - 1'b1);
                    end
                end else if (cnt_q[g] >= top[g]) begin
                    dn_d[g] = 1'b1;
                    cnt_d[g] = PERIOD_W'(cnt_q[g] - PERIOD_W'(cnt_q[g] != '0));
                end else begin
                    cnt_d[g] = PERIOD_W'(cnt_q[g] + 1'b1);
                end
            end else begin
                dn_d[g] = 1'b1;
                if (cnt_q[g] != '0) begin
                    cnt_d[g] = PERIOD_W'(cnt_q[g] - 1'b1);
                end else if (upd_q[g]) begin
                    cnt_d[g] = PERIOD_W'(perp_q[g] - 1'b1); // see [RL2]
                end else begin
                    cnt_d[g] = top[g];
                end
            end
            if (upd_q[g] && (ev[g].counter_zero || !ctrl_q[g])) begin
                per_d[g] = perp_q[g]; // see [RL13]
                cmpa_d[g] = cmpap_q[g];
                cmpb_d[g] = cmpbp_q[g];
                upd_d[g] = 1'b0;
            end
            if (wgen[g]) begin
                case (off)
                    ppifc_pkg::OFF_GCTL: gcfg_d[g] = hwdata_in[4:0];
                    ppifc_pkg::OFF_PERIOD: begin
                        // later write overwrites the pending value
                        perp_d[g] = hwdata_in[PERIOD_W-1:0]; // see [RL3] see [RL4]
                        upd_d[g] = 1'b1;
                    end
                    ppifc_pkg::OFF_CMPA: begin
                        cmpap_d[g] = hwdata_in[PERIOD_W-1:0]; // see [RL13]
                        upd_d[g] = 1'b1;
                    end
                    ppifc_pkg::OFF_CMPB: begin
                        cmpbp_d[g] = hwdata_in[PERIOD_W-1:0];
                        upd_d[g] = 1'b1;
                    end
                    ppifc_pkg::OFF_GIEN: gien_d[g] = hwdata_in[13:0]; // see [RL1]
                    ppifc_pkg::OFF_GRIS, ppifc_pkg::OFF_GMIS:
                        gris_d[g] = gris_q[g] & ~hwdata_in[5:0]; // see [RL12]
                    default: ;
                endcase
            end
            // a new event wins over a clear in the same cycle
            gris_d[g] = gris_d[g] | ev[g];
            trig_d[g] = |(ev[g] & gien_q[g][ppifc_pkg::TRIG_LSB +: 6]); // see [RL1]
            mris_d[g] = |(gris_q[g] & gien_q[g][5:0]); // see [RL6]
            if (wmod && (off == ppifc_pkg::OFF_MRIS || off == ppifc_pkg::OFF_MMIS)) begin
                mris_d[g + 4] = mris_q[g + 4] & ~hwdata_in[g + 4];
            end
            mris_d[g + 4] = mris_d[g + 4] | fault_adj[g];
        end
        for (int i = 0; i < 8; i++) begin
            pwm_d[i] = ctrl_q[i / 2] && cnt_q[i / 2] < (i % 2 == 1 ? cmpb_q[i / 2] :
                cmpa_q[i / 2]); // see [RL8]
            if (gfault[i / 2] && supp_q[i]) begin
                // level bit only counts with extended handling on
                pwm_d[i] = ext && flvl_q[i]; // see [RL7] see [RL9] see [RL10] see [RL11]
            end
        end
        irq_d = |(mris_d & mien_d); // see [RL15]
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl_q <= '0;
            mien_q <= '0;
            supp_q <= '0;
            flvl_q <= '0;
            sense_q <= '0;
            for (int g = 0; g < 4; g++) begin
                gcfg_q[g] <= '{fault_src: ppifc_pkg::FAULT_SRC_RST, updown: 1'b0};
            end
            cnt_q <= '0;
            dn_q <= '0;
            per_q <= '0;
            perp_q <= '0;
            cmpa_q <= '0;
            cmpap_q <= '0;
            cmpb_q <= '0;
            cmpbp_q <= '0;
            upd_q <= '0;
            gien_q <= '0;
            gris_q <= '0;
            trig_q <= '0;
            mris_q <= '0;
            pwm_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mien_q <= mien_d;
            supp_q <= supp_d;
            flvl_q <= flvl_d;
            sense_q <= sense_d;
            gcfg_q <= gcfg_d;
            cnt_q <= cnt_d;
            dn_q <= dn_d;
            per_q <= per_d;
            perp_q <= perp_d;
            cmpa_q <= cmpa_d;
            cmpap_q <= cmpap_d;
            cmpb_q <= cmpb_d;
            cmpbp_q <= cmpbp_d;
            upd_q <= upd_d;
            gien_q <= gien_d;
            gris_q <= gris_d;
            trig_q <= trig_d;
            mris_q <= mris_d;
            pwm_q <= pwm_d;
            irq_q <= irq_d;
        end
    end
endmodule // ppifc_pwm
`default_nettype wire

// ==== verification/ppifc_pwm_asserts.sv ====
/*
 port checker for the pwm block, bound into ppifc_pwm.
 assumes hready_in is the block's own hreadyout_out.
*/
`timescale 1ns/1ns
`default_nettype none
module ppifc_pwm_asserts #(
    parameter int PERIOD_W = 16
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [3:0] fault_in,
    input wire logic [7:0] pwm_out,
    input wire logic [3:0] trig_out,
    input wire logic irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // shadows of the fault and enable registers, snooped from write data phases
    logic ap_q, ap_d, ext_q, ext_d;
    logic [8:0] a_q, a_d;
    logic [7:0] supp_q, supp_d, flvl_q, flvl_d, mien_q, mien_d;
    always_comb begin
        ap_d = hready_in ? (hsel_in && htrans_in[1] && hwrite_in) : ap_q;
        a_d = hready_in ? haddr_in[8:0] : a_q;
        supp_d = (ap_q && hready_in && a_q == 9'h010) ? hwdata_in[7:0] : supp_q;
        flvl_d = (ap_q && hready_in && a_q == 9'h014) ? hwdata_in[7:0] : flvl_q;
        mien_d = (ap_q && hready_in && a_q == 9'h004) ? hwdata_in[7:0] : mien_q;
        ext_d = (ap_q && hready_in && a_q == 9'h000) ? hwdata_in[4] : ext_q;
    end
    always_ff @(posedge mclk_in) begin
        ap_q <= sys_rst_in ? 1'b0 : ap_d;
        a_q <= sys_rst_in ? 9'h000 : a_d;
        supp_q <= sys_rst_in ? 8'h00 : supp_d;
        flvl_q <= sys_rst_in ? 8'h00 : flvl_d;
        mien_q <= sys_rst_in ? 8'h00 : mien_d;
        ext_q <= sys_rst_in ? 1'b0 : ext_d;
    end
    rd_stall_a: assert property (hsel_in && htrans_in[1] && hready_in && !hwrite_in
        |=> !hreadyout_out ##1 hreadyout_out) else $error("read stall not one cycle");
    wr_ready_a: assert property (hsel_in && htrans_in[1] && hready_in && hwrite_in
        |=> hreadyout_out) else $error("write data phase stalled");
    stall_cause_a: assert property ($fell(hreadyout_out) |-> $past(htrans_in[1])
        && !$past(hwrite_in)) else $error("stall without a read");
    okay_resp_a: assert property (!hresp_out) else $error("response not okay");
    rst_quiet_a: assert property ($fell(sys_rst_in) |-> pwm_out == 8'h00
        && trig_out == 4'h0 && !irq_out && hreadyout_out) else $error("outputs not idle");
    // settings in force in the fault cycle decide the level, not a write landing then
    fault_level_a: assert property (fault_in[0] |=>
        (pwm_out & $past(supp_q)) == ($past(supp_q) & $past(flvl_q) & {8{$past(ext_q)}}))
        else $error("suppressed output level wrong");
    irq_mask_a: assert property (mien_d == 8'h00 |=> !irq_out)
        else $error("interrupt with all sources masked");
    irq_fault_a: assert property (fault_in[0] && mien_d[4] |-> ##[1:2] irq_out)
        else $error("fault interrupt missing");
endmodule // ppifc_pwm_asserts
bind ppifc_pwm ppifc_pwm_asserts #(.PERIOD_W(PERIOD_W)) chk_i (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .fault_in(fault_in), .pwm_out(pwm_out), .trig_out(trig_out), .irq_out(irq_out));
`default_nettype wire

// ==== verification/ppifc_stage.sv ====
/*
 power stage on the pwm pins: raises fault lines when the bench orders a trip.
 assumes trips are commanded on the block's clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ppifc_stage (
    input wire logic mclk_in,
    input wire logic [3:0] trip_in,
    input wire logic [7:0] pwm_in,
    output logic [3:0] fault_out
);
    // registered, so a trip reaches the block one edge after it is ordered
    initial fault_out = 4'h0;
    always @(posedge mclk_in) fault_out <= trip_in;
endmodule // ppifc_stage
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 self-checking bench for the pwm block: ahb-lite tasks and directed tests.
 assumes the power stage model and the bound port checker.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [2:0] M = ppifc_pkg::MOD_BLK;
    localparam logic [2:0] G0 = 3'h1;
    localparam logic [2:0] G1 = 3'h2;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q, n;
    logic hready, hresp, irq;
    logic [3:0] fault, trig, trip = 4'h0;
    logic [7:0] pwm;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    always #10 mclk_in = ~mclk_in;
    ppifc_pwm #(.PERIOD_W(16)) uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .fault_in(fault), .pwm_out(pwm),
        .trig_out(trig), .irq_out(irq));
    ppifc_stage stage (.mclk_in(mclk_in), .trip_in(trip), .pwm_in(pwm), .fault_out(fault));
    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, msk);
        n_compared++;
        if ((got & msk) !== (exp & msk)) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got & msk, exp & msk);
        end
    endtask
    function automatic logic [31:0] ad(input logic [2:0] b, input logic [5:0] o);
        ad = {23'h00_0000, b, o};
    endfunction
    // one single transfer; the address phase is held until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk_in); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, exp, msk);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, exp, msk);
    endtask
    // ticks between two trigger pulses of generator 0
    task automatic gap;
        do @(posedge mclk_in); while (trig[0] !== 1'b1);
        n = 32'h0000_0000;
        do begin
            @(posedge mclk_in);
            n = n + 32'h0000_0001;
        end while (trig[0] !== 1'b1);
    endtask
    // interrupt in bit 8, outputs 7..0 below it
    task automatic pw(input logic [31:0] exp);
        repeat (4) @(posedge mclk_in);
        chk({23'h00_0000, irq, pwm}, exp, 32'h0000_01FF);
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        rdc(ad(G0, ppifc_pkg::OFF_GCTL), {27'h000_0000, ppifc_pkg::FAULT_SRC_RST, 1'b0},
            ALL);
        wr(ad(3'h7, 6'h00), ALL);
        rdc(ad(3'h7, 6'h00), 32'h0000_0000, ALL);
        wr(ad(G0, ppifc_pkg::OFF_PERIOD), 32'h0000_0008);
        wr(ad(G0, ppifc_pkg::OFF_GIEN), 32'h0000_0101);
        wr(ad(M, ppifc_pkg::OFF_CTRL), 32'h0000_0001);
        gap();
        chk(n, 32'h0000_0008, ALL);
        wr(ad(G0, ppifc_pkg::OFF_PERIOD), 32'h0000_0006);
        wr(ad(G0, ppifc_pkg::OFF_PERIOD), 32'h0000_0004);
        rdc(ad(G0, ppifc_pkg::OFF_PERIOD), 32'h0000_0004, ALL);
        gap();
        gap();
        chk(n, 32'h0000_0004, ALL);
        // up/down counting keeps the same zero-to-zero spacing
        wr(ad(G0, ppifc_pkg::OFF_GCTL), 32'h0000_0003);
        gap();
        gap();
        chk(n, 32'h0000_0004, ALL);
        wr(ad(M, ppifc_pkg::OFF_CTRL), 32'h0000_0000);
        rdc(ad(G0, ppifc_pkg::OFF_GRIS), 32'h0000_0001, 32'h0000_0001);
        rdc(ad(G0, ppifc_pkg::OFF_GMIS), 32'h0000_0001, 32'h0000_0001);
        wr(ad(G0, ppifc_pkg::OFF_GIEN), 32'h0000_0100);
        rdc(ad(G0, ppifc_pkg::OFF_GMIS), 32'h0000_0000, 32'h0000_0001);
        wr(ad(G0, ppifc_pkg::OFF_GRIS), 32'h0000_0000);
        rdc(ad(G0, ppifc_pkg::OFF_GRIS), 32'h0000_0001, 32'h0000_0001);
        wr(ad(G0, ppifc_pkg::OFF_GRIS), 32'h0000_0001);
        rdc(ad(G0, ppifc_pkg::OFF_GRIS), 32'h0000_0000, 32'h0000_0001);
        // stopped generators drive low, so run two: out1 and out2 high, out0 and out3 low
        wr(ad(G0, ppifc_pkg::OFF_CMPB), 32'h0000_FFFF);
        wr(ad(G1, ppifc_pkg::OFF_CMPA), 32'h0000_FFFF);
        wr(ad(M, ppifc_pkg::OFF_CTRL), 32'h0000_0003);
        wr(ad(M, ppifc_pkg::OFF_SUPP), 32'h0000_0003);
        wr(ad(M, ppifc_pkg::OFF_FLVL), 32'h0000_0009);
        wr(ad(M, ppifc_pkg::OFF_MIEN), 32'h0000_0010);
        trip <= 4'h2;
        pw(32'h0000_0006);
        trip <= 4'h1;
        pw(32'h0000_0104);
        rdc(ad(M, ppifc_pkg::OFF_MRIS), 32'h0000_0010, 32'h0000_0010);
        rdc(ad(M, ppifc_pkg::OFF_MMIS), 32'h0000_0010, 32'h0000_0010);
        wr(ad(M, ppifc_pkg::OFF_MIEN), 32'h0000_0000);
        pw(32'h0000_0004);
        rdc(ad(M, ppifc_pkg::OFF_MRIS), 32'h0000_0010, 32'h0000_0010);
        rdc(ad(M, ppifc_pkg::OFF_MMIS), 32'h0000_0000, 32'h0000_0010);
        wr(ad(M, ppifc_pkg::OFF_MIEN), 32'h0000_0010);
        wr(ad(M, ppifc_pkg::OFF_CTRL), 32'h0000_0013);
        pw(32'h0000_0105);
        trip <= 4'h0;
        pw(32'h0000_0106);
        wr(ad(M, ppifc_pkg::OFF_MRIS), 32'h0000_0010);
        pw(32'h0000_0006);
        rdc(ad(M, ppifc_pkg::OFF_MRIS), 32'h0000_0000, 32'h0000_0010);
        test_done();
    end
endmodule // testbench
`default_nettype wire
